// *** dv/pho_far_model.sv ***
/*
 * far side of the holdover controller: reference source with a
 * feedback edge that follows it, and the lock pin with its capacitor.
 * assumes the bench starts and stops the reference and sets the
 * capacitor level that the lock pin shows while nobody drives it.
 */
`timescale 1ns/1ps
`default_nettype none
module pho_far_model (
   input  wire logic run_i,
   input  wire logic cap_lvl_i,
   input  wire logic pin_o_i,
   input  wire logic pin_oe_i,
   output logic      ref_pfd_o,
   output logic      fb_pfd_o,
   output logic      lock_pin_o,
   output logic      analog_lock_o
);
   initial ref_pfd_o = 1'b0;
   initial fb_pfd_o  = 1'b0;
   // free phase against the core clock; stands low while stopped
   always
   begin
      #28;
      ref_pfd_o = run_i ? ~ref_pfd_o : 1'b0;
   end
   // feedback well inside the lock window, so the loop reads as locked
   always @(ref_pfd_o) fb_pfd_o <= #2 ref_pfd_o;
   assign lock_pin_o    = pin_oe_i ? pin_o_i : cap_lvl_i;
   assign analog_lock_o = run_i;
endmodule
`default_nettype wire

// *** dv/pho_holdover_ctrl_asserts.sv ***
/*
 * port checker for the holdover controller.
 * assumes hready_i is tied to hreadyout_o by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module pho_holdover_ctrl_asserts (
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       hsel_i,
   input  wire logic [1:0] htrans_i,
   input  wire logic       hwrite_i,
   input  wire logic       hready_i,
   input  wire logic       hreadyout_o,
   input  wire logic       hresp_o,
   input  wire logic       ref_pfd_i,
   input  wire logic       hold_req_n_i,
   input  wire logic       lock_indicator_pin_i,
   input  wire logic       cp_hiz_o,
   input  wire logic       b_cnt_rst_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire take = hsel_i & htrans_i[1] & hready_i;
   sequence rd_wait_s;
      !hreadyout_o ##1 hreadyout_o;
   endsequence
   sequence released_s;
      $fell(cp_hiz_o) ##0 b_cnt_rst_o;
   endsequence
   bus_okay_a: assert property (hresp_o == 1'b0)
      else $error("response not okay");
   rd_wait_a: assert property (take && !hwrite_i |=> rd_wait_s)
      else $error("read wait state wrong");
   wr_nowait_a: assert property (take && hwrite_i |=> hreadyout_o)
      else $error("write stalled");
   bcnt_release_a: assert property ($fell(cp_hiz_o) |-> released_s)
      else $error("b counter reset missing at release");
   bcnt_only_a: assert property (b_cnt_rst_o |-> $fell(cp_hiz_o))
      else $error("b counter reset without release");
   bcnt_pulse_a: assert property (b_cnt_rst_o |=> !b_cnt_rst_o)
      else $error("b counter reset longer than a cycle");
   release_ref_a: assert property ($fell(cp_hiz_o) |->
      $past(ref_pfd_i, 2) && $past(hold_req_n_i, 2))
      else $error("release without reference edge");
   entry_cause_a: assert property ($rose(cp_hiz_o) |->
      !$past(hold_req_n_i, 2) || !$past(lock_indicator_pin_i, 2))
      else $error("holdover entered without cause");
   cover property (released_s);
endmodule
bind pho_holdover_ctrl pho_holdover_ctrl_asserts u_pho_holdover_ctrl_asserts (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ref_pfd_i(ref_pfd_i),
   .hold_req_n_i(hold_req_n_i),
   .lock_indicator_pin_i(lock_indicator_pin_i),
   .cp_hiz_o(cp_hiz_o), .b_cnt_rst_o(b_cnt_rst_o));
`default_nettype wire

// *** dv/pho_holdover_ctrl_test.sv ***
/*
 * self-checking bench: ahb-lite master, register model, holdover runs.
 * assumes the far-side model supplies reference and lock pin levels.
 */
`timescale 1ns/1ps
`default_nettype none
module pho_holdover_ctrl_test;
   import pho_pkg::*;
   logic        core_clk_i = 1'b0, sys_rst_i = 1'b1;
   logic        hsel = 1'b0, hwrite = 1'b0, req_n = 1'b1;
   logic        run = 1'b0, cap = 1'b1;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, v;
   logic [1:0]  htrans = '0, bufe;
   logic [2:0]  hsize = HSIZE_WORD;
   logic        hrdy, hresp, rpfd, fpfd, lki, lko, lkoe, chg, alf;
   logic        hiz, brst, dlf, aut, pref;
   logic [3:0]  coff;
   logic [31:0] seed = 32'h86cd_42a8;
   int          bad_count = 0, samples_checked = 0, cyc = 0;
   int          regm [int];
   logic [9:0]  ix [8] = '{10'h018, 10'h01A, 10'h01C, 10'h01D,
                           10'h191, 10'h194, 10'h197, 10'h19A};
   logic [7:0]  mk [8] = '{8'h78, 8'h3F, 8'h1E, 8'h0B,
                           8'h40, 8'h40, 8'h40, 8'h40};
   pho_holdover_ctrl u_pho_holdover_ctrl (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
      .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
      .ref_pfd_i(rpfd), .fb_pfd_i(fpfd), .hold_req_n_i(req_n),
      .lock_indicator_pin_i(lki), .lock_indicator_pin_o(lko),
      .lock_indicator_pin_oe_o(lkoe), .lock_pin_charge_o(chg),
      .analog_lock_flag_i(alf), .cp_hiz_o(hiz), .b_cnt_rst_o(brst),
      .digital_lock_flag_o(dlf), .chan_off_o(coff),
      .ref_auto_sw_o(aut), .ref_prefer_second_o(pref),
      .ref_buf_en_o(bufe));
   pho_far_model u_pho_far_model (
      .run_i(run), .cap_lvl_i(cap), .pin_o_i(lko), .pin_oe_i(lkoe),
      .ref_pfd_o(rpfd), .fb_pfd_o(fpfd), .lock_pin_o(lki),
      .analog_lock_o(alf));
   initial forever #4 core_clk_i = ~core_clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t bus got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t pin got %h want %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // one single transfer; the model keeps what a write should leave
   task automatic bus(input logic wr, input logic [9:0] idx,
                      input logic [31:0] wd, output logic [31:0] rdv);
      int k;
      @(posedge core_clk_i);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {20'h0_0000, idx, 2'b00};
      do @(posedge core_clk_i); while (hrdy !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge core_clk_i); while (hrdy !== 1'b1);
      rdv = hrdata;
      for (k = 0; k < 8; k++)
         if (wr && ix[k] == idx) regm[idx] = int'(wd[7:0] & mk[k]);
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
      bus(1'b1, idx, wd, rd);
   endtask
   task automatic rd_chk(input logic [9:0] idx);
      bus(1'b0, idx, '0, rd);
      chk_word(rd, regm.exists(int'(idx)) ? regm[int'(idx)] : 0);
   endtask
   task automatic wait_rel();
      for (int k = 0; k < 100 && hiz !== 1'b0; k++) step(1);
      chk_pin(hiz, 0);
      chk_pin(brst, 1);
   endtask
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         report_and_stop();
      end
   end
   initial
   begin
      step(16);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         rd_chk(ix[i]);
         wr(ix[i], 32'hFFFF_FFFF);
         rd_chk(ix[i]);
      end
      rd_chk(10'h100);
      chk_pin({aut, pref, bufe}, 4'hF);
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         v = seed;
         wr(IDX_REF_CTL, v);
         rd_chk(IDX_REF_CTL);
         chk_pin({aut, pref, bufe}, v[4:1]);
      end
      wr(IDX_LOCK_DET, 32'h0000_0000);
      wr(10'h197, 32'h0000_0000);
      wr(10'h19A, 32'h0000_0000);
      wr(IDX_HOLD_CTL, 32'h0000_0003);
      req_n <= 1'b0;
      step(6);
      chk_pin(hiz, 1);
      chk_pin(coff, 4'b1100);
      bus(1'b0, IDX_STATUS, '0, rd);
      chk_word(rd & 32'h0000_0003, 32'h0000_0001);
      req_n <= 1'b1;
      step(20);
      chk_pin(hiz, 1);
      run <= 1'b1;
      wait_rel();
      run <= 1'b0;
      wr(IDX_HOLD_CTL, 32'h0000_0002);
      req_n <= 1'b0;
      step(6);
      chk_pin(hiz, 0);
      req_n <= 1'b1;
      wr(IDX_PIN_CTL, 32'h0000_0000);
      wr(IDX_HOLD_CTL, 32'h0000_0009);
      cap <= 1'b0;
      step(40);
      chk_pin(hiz, 1);
      run <= 1'b1;
      wait_rel();
      step(10);
      chk_pin(hiz, 0);
      bus(1'b0, IDX_STATUS, '0, rd);
      chk_word(rd & 32'h0000_0003, 32'h0000_0002);
      cap <= 1'b1;
      step(6);
      cap <= 1'b0;
      // reference runs, so look before the next edge can release
      step(4);
      chk_pin(hiz, 1);
      wait_rel();
      wr(IDX_HOLD_CTL, 32'h0000_0001);
      step(10);
      chk_pin(hiz, 0);
      step(60);
      chk_pin(dlf, 1);
      wr(IDX_PIN_CTL, 32'h0000_0004);
      step(3);
      chk_pin({chg, lkoe}, 2'b10);
      wr(IDX_PIN_CTL, 32'h0000_0001);
      step(3);
      chk_pin({lkoe, lko}, 2'b11);
      wr(IDX_PIN_CTL, 32'h0000_0002);
      step(3);
      chk_pin({lkoe, lko}, 2'b11);
      wr(IDX_LOCK_DET, 32'h0000_0008);
      step(5);
      chk_pin(dlf, 0);
      sys_rst_i <= 1'b1;
      step(3);
      sys_rst_i <= 1'b0;
      regm.delete();
      rd_chk(IDX_HOLD_CTL);
      report_and_stop();
   end
endmodule
`default_nettype wire

// *** verilog/pho_holdover_ctrl.sv ***
/*
 * holdover controller: ahb-lite register slave, holdover state
 * machine, lock pin driver and channel request gating.
 * assumes pins are asynchronous and one core clock domain.
 */
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - holdover enable bit gates both manual and automatic holdover
// - holdover means charge pump tristated, never pumped up or down
// - manual holdover starts on request pin falling edge only
// - manual release waits request high and next reference edge
// - b counter resets at the release event; prescaler untouched
// - per-channel ignore bits keep channels running on request low
// - automatic holdover starts when sensed lock level is low
// - comparator off makes sensed lock level permanently high
// - after automatic holdover, rearm only once lock is seen again
// - holdover follows the selected reference; switch losses brief
// - lock needs programmable consecutive in-window cycles, 00 is five
// - digital lock detector runs only while its disable bit is zero
// - pin code 000100b selects current-source lock detect
// - trigger bit zero selects automatic loss-of-lock holdover
// - reference control: auto switch, preference, buffer enables
// - window bit zero selects the high-range lock window
// - automatic holdover holds while no reference edge arrives
// - sensed lock level may come from any lock detect source
// - lock stays until one cycle exceeds the wider unlock threshold
module pho_holdover_ctrl (
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        ref_pfd_i,
   input  wire logic        fb_pfd_i,
   input  wire logic        hold_req_n_i,
   input  wire logic        lock_indicator_pin_i,
   output logic             lock_indicator_pin_o,
   output logic             lock_indicator_pin_oe_o,
   output logic             lock_pin_charge_o,
   input  wire logic        analog_lock_flag_i,
   output logic             cp_hiz_o,
   output logic             b_cnt_rst_o,
   output logic             digital_lock_flag_o,
   output logic      [3:0]  chan_off_o,
   output logic             ref_auto_sw_o,
   output logic             ref_prefer_second_o,
   output logic      [1:0]  ref_buf_en_o
);
   import pho_pkg::*;

   // synchronised pins: ref, fb, request, lock pin, analog lock
   logic [4:0] pin_s;
   pho_sync #(
      .W   (5),
      .RST (5'h04)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .async_i    ({ref_pfd_i, fb_pfd_i, hold_req_n_i,
                    lock_indicator_pin_i, analog_lock_flag_i}),
      .sync_o     (pin_s)
   );
   wire ref_s    = pin_s[4];
   wire fb_s     = pin_s[3];
   wire req_s    = pin_s[2];
   wire lpin_s   = pin_s[1];
   wire analog_s = pin_s[0];

   logic ref_q_reg;
   logic fb_q_reg;
   logic req_q_reg;
   wire  ref_edge = ref_s & ~ref_q_reg;
   wire  fb_edge  = fb_s & ~fb_q_reg;
   wire  req_fall = req_q_reg & ~req_s;

   // registers
   logic [7:0] ld_cfg_reg;
   logic [7:0] pin_ctl_reg;
   logic [7:0] ref_ctl_reg;
   logic [7:0] ho_ctl_reg;
   logic [3:0] ign_reg;

   // ahb-lite slave: writes take no wait, reads take one wait state
   logic       wr_pend_reg;
   logic       rd_wait_reg;
   logic [9:0] idx_reg;
   wire  [9:0] a_idx   = haddr_i[11:2];
   wire        a_ok    = (haddr_i[31:12] == 20'h0_0000)
                         && (haddr_i[1:0] == 2'b00);
   wire        a_phase = hsel_i & htrans_i[1] & hready_i;
   wire        a_wr    = a_phase & hwrite_i & a_ok
                         & (hsize_i == HSIZE_WORD);
   wire        a_rd    = a_phase & ~hwrite_i;
   wire [7:0]  wdat    = hwdata_i[7:0];
   wire        wr_ld   = wr_pend_reg && idx_reg == IDX_LOCK_DET;
   wire        wr_pin  = wr_pend_reg && idx_reg == IDX_PIN_CTL;
   wire        wr_ref  = wr_pend_reg && idx_reg == IDX_REF_CTL;
   wire        wr_ho   = wr_pend_reg && idx_reg == IDX_HOLD_CTL;

   // holdover state
   pho_state_e state_reg;
   pho_state_e state_next;
   logic       b_next;
   logic       digital_lock_flag;
   wire        ho_en   = ho_ctl_reg[HO_EN_BIT];
   wire        manual  = ho_ctl_reg[HO_EXT_BIT];
   wire        cmp_en  = ho_ctl_reg[HO_CMP_BIT];
   // any detector may drive the pin; only the sensed level matters
   wire        lock_ok = cmp_en ? lpin_s : 1'b1;
   wire [1:0]  st_code = state_reg;
   wire [7:0]  status  = {4'h0, lock_ok, digital_lock_flag, st_code};

   // read selection
   logic [7:0] ch_rd [4];
   logic [3:0] ch_hit;
   wire [7:0]  rd_val  =
      (idx_reg == IDX_LOCK_DET) ? ld_cfg_reg  :
      (idx_reg == IDX_PIN_CTL)  ? pin_ctl_reg :
      (idx_reg == IDX_REF_CTL)  ? ref_ctl_reg :
      (idx_reg == IDX_HOLD_CTL) ? ho_ctl_reg  :
      (idx_reg == IDX_STATUS)   ? status      :
      ch_hit[0] ? ch_rd[0] :
      ch_hit[1] ? ch_rd[1] :
      ch_hit[2] ? ch_rd[2] :
      ch_hit[3] ? ch_rd[3] : 8'h00;

   assign hreadyout_o = ~rd_wait_reg;
   assign hresp_o     = 1'b0;

   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         wr_pend_reg <= 1'b0;
         rd_wait_reg <= 1'b0;
         idx_reg     <= 10'h000;
         hrdata_o    <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_reg <= a_wr;
         rd_wait_reg <= a_rd;
         if (a_phase)
            idx_reg <= a_ok ? a_idx : 10'h3FF;
         // loaded in the wait state, so a write just before is seen
         if (rd_wait_reg)
            hrdata_o <= {24'h00_0000, rd_val};
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ld_cfg_reg  <= RST_REG;
         pin_ctl_reg <= RST_REG;
         ref_ctl_reg <= RST_REG;
         ho_ctl_reg  <= RST_REG;
      end
      else
      begin
         if (wr_ld)
            ld_cfg_reg <= wdat & MSK_LOCK_DET;
         if (wr_pin)
            pin_ctl_reg <= wdat & MSK_PIN_CTL;
         if (wr_ref)
            ref_ctl_reg <= wdat & MSK_REF_CTL;
         if (wr_ho)
            ho_ctl_reg <= wdat & MSK_HOLD_CTL;
      end
   end

   // per-channel ignore bits and output gating
   genvar c;
   generate
      for (c = 0; c < 4; c++)
      begin : g_ch
         assign ch_hit[c] = (idx_reg == IDX_CH[c]);
         assign ch_rd[c]  = {1'b0, ign_reg[c], 6'h00};
         always_ff @(posedge core_clk_i or posedge sys_rst_i)
         begin
            if (sys_rst_i)
            begin
               ign_reg[c]    <= RST_REG[CH_IGN_BIT];
               chan_off_o[c] <= 1'b0;
            end
            else
            begin
               if (wr_pend_reg && ch_hit[c])
                  ign_reg[c] <= wdat[CH_IGN_BIT];
               chan_off_o[c] <= ~req_s & ~ign_reg[c];
            end
         end
      end
   endgenerate

   // digital lock detector
   pho_ld_cfg_s ld_cfg;
   assign ld_cfg.dis      = ld_cfg_reg[LD_DIS_BIT];
   assign ld_cfg.win_lo   = ld_cfg_reg[LD_WIN_BIT];
   assign ld_cfg.cnt_code = ld_cfg_reg[LD_CNT_LSB +: 2];
   pho_lock_det u_ld (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .cfg_i      (ld_cfg),
      .ref_edge_i (ref_edge),
      .fb_edge_i  (fb_edge),
      .lock_o     (digital_lock_flag)
   );

   // holdover state machine; entries act at once, exits from hold only on a
   // reference edge or a cleared enable bit, so a missing reference keeps the pump tristated
   always_comb
   begin
      state_next = state_reg;
      b_next     = 1'b0;
      if (!ho_en)
         state_next = ST_IDLE;
      else
      begin
         unique case (state_reg)
            ST_IDLE:
            begin
               if (manual && req_fall)
                  state_next = ST_HOLD;
               else if (!manual && !lock_ok)
                  state_next = ST_HOLD;
            end
            ST_HOLD:
            begin
               if (ref_edge && (!manual || req_s))
               begin
                  state_next = manual ? ST_IDLE : ST_RELOCK;
                  b_next     = 1'b1;
               end
            end
            ST_RELOCK:
            begin
               if (manual && req_fall)
                  state_next = ST_HOLD;
               else if (lock_ok)
                  state_next = ST_IDLE;
            end
         endcase
      end
   end

   // lock pin driver mux
   wire [5:0] pcode   = pin_ctl_reg[5:0];
   wire       p_dld   = (pcode == PIN_DLD);
   wire       p_ald   = (pcode == PIN_ALD);
   wire       p_csld  = (pcode == PIN_CSLD);

   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_reg               <= ST_IDLE;
         cp_hiz_o                <= 1'b0;
         b_cnt_rst_o             <= 1'b0;
         ref_q_reg               <= 1'b0;
         fb_q_reg                <= 1'b0;
         req_q_reg               <= 1'b1;
         digital_lock_flag_o     <= 1'b0;
         lock_indicator_pin_o    <= 1'b0;
         lock_indicator_pin_oe_o <= 1'b0;
         lock_pin_charge_o       <= 1'b0;
      end
      else
      begin
         state_reg           <= state_next;
         cp_hiz_o            <= (state_next == ST_HOLD);
         b_cnt_rst_o         <= b_next;
         ref_q_reg           <= ref_s;
         fb_q_reg            <= fb_s;
         req_q_reg           <= req_s;
         digital_lock_flag_o <= digital_lock_flag;
         lock_indicator_pin_o <= p_dld ? digital_lock_flag : (p_ald ? analog_s : 1'b0);
         // current source: charge while locked, short to ground if not
         lock_indicator_pin_oe_o <= p_dld | p_ald | (p_csld & ~digital_lock_flag);
         lock_pin_charge_o       <= p_csld & digital_lock_flag;
      end
   end

   assign ref_auto_sw_o       = ref_ctl_reg[REF_AUTO_BIT];
   assign ref_prefer_second_o = ref_ctl_reg[REF_PREF_BIT];
   assign ref_buf_en_o        = ref_ctl_reg[REF_BUF_LSB +: 2];
endmodule
`default_nettype wire

// *** verilog/pho_lock_det.sv ***
/*
 * digital lock detector: measures the gap between reference and
 * feedback phase-detector edges. assumes one-cycle edge pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module pho_lock_det (
   input  wire logic                 core_clk_i,
   input  wire logic                 sys_rst_i,
   input  wire pho_pkg::pho_ld_cfg_s cfg_i,
   input  wire logic                 ref_edge_i,
   input  wire logic                 fb_edge_i,
   output logic                      lock_o
);
   import pho_pkg::*;
   logic       open_reg;
   logic       ref_first_reg;
   logic [7:0] gap_reg;
   logic [7:0] cnt_reg;
   wire  any_edge  = ref_edge_i | fb_edge_i;
   wire  both_now  = ref_edge_i & fb_edge_i;
   wire  close_now = open_reg & (ref_first_reg ? fb_edge_i : ref_edge_i);
   wire  eval      = both_now | close_now;
   wire [7:0] gap  = both_now ? 8'h00 : gap_reg;
   wire [7:0] lthr = cfg_i.win_lo ? LOCK_THR_LO : LOCK_THR_HI;
   wire [7:0] uthr = cfg_i.win_lo ? UNLOCK_THR_LO : UNLOCK_THR_HI;
   wire  in_win    = gap < lthr;
   wire  out_win   = gap > uthr;
   wire [7:0] need = LOCK_CNT[cfg_i.cnt_code];
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         open_reg      <= 1'b0;
         ref_first_reg <= 1'b0;
         gap_reg       <= 8'h00;
         cnt_reg       <= 8'h00;
         lock_o        <= 1'b0;
      end
      else if (cfg_i.dis)
      begin
         open_reg <= 1'b0;
         cnt_reg  <= 8'h00;
         lock_o   <= 1'b0;
      end
      else
      begin
         if (eval)
            open_reg <= 1'b0;
         else if (any_edge & ~open_reg)
         begin
            open_reg      <= 1'b1;
            ref_first_reg <= ref_edge_i;
            gap_reg       <= 8'h00;
         end
         else if (open_reg && gap_reg != 8'hFF)
            gap_reg <= gap_reg + 8'h01;
         if (eval && lock_o && out_win)
         begin
            lock_o  <= 1'b0;
            cnt_reg <= 8'h00;
         end
         else if (eval && !lock_o)
         begin
            cnt_reg <= in_win ? cnt_reg + 8'h01 : 8'h00;
            lock_o  <= in_win && (cnt_reg + 8'h01 >= need);
         end
      end
   end
endmodule
`default_nettype wire

// *** verilog/pho_pkg.sv ***
/*
 * constants, types and register map of the pll holdover controller.
 * assumes 8-bit registers, each in one aligned 32-bit ahb word.
 */
`default_nettype none
package pho_pkg;
   // printed offsets are register indices; byte address is index * 4
   localparam logic [9:0] IDX_LOCK_DET = 10'h018;
   localparam logic [9:0] IDX_PIN_CTL  = 10'h01A;
   localparam logic [9:0] IDX_REF_CTL  = 10'h01C;
   localparam logic [9:0] IDX_HOLD_CTL = 10'h01D;
   localparam logic [9:0] IDX_STATUS   = 10'h1F8;
   localparam logic [9:0] IDX_CH [4]   = '{10'h191, 10'h194,
                                           10'h197, 10'h19A};
   localparam int LD_CNT_LSB   = 5;
   localparam int LD_WIN_BIT   = 4;
   localparam int LD_DIS_BIT   = 3;
   localparam int REF_AUTO_BIT = 4;
   localparam int REF_PREF_BIT = 3;
   localparam int REF_BUF_LSB  = 1;
   localparam int HO_CMP_BIT   = 3;
   localparam int HO_EXT_BIT   = 1;
   localparam int HO_EN_BIT    = 0;
   localparam int CH_IGN_BIT   = 6;
   localparam logic [7:0] MSK_LOCK_DET = 8'h78;
   localparam logic [7:0] MSK_PIN_CTL  = 8'h3F;
   localparam logic [7:0] MSK_REF_CTL  = 8'h1E;
   localparam logic [7:0] MSK_HOLD_CTL = 8'h0B;
   localparam logic [7:0] RST_REG      = 8'h00;
   localparam logic [5:0] PIN_DLD  = 6'h01;
   localparam logic [5:0] PIN_ALD  = 6'h02;
   localparam logic [5:0] PIN_CSLD = 6'h04;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // edge-difference thresholds, in core clock cycles
   localparam logic [7:0] LOCK_THR_HI   = 8'h08;
   localparam logic [7:0] UNLOCK_THR_HI = 8'h10;
   localparam logic [7:0] LOCK_THR_LO   = 8'h02;
   localparam logic [7:0] UNLOCK_THR_LO = 8'h04;
   localparam logic [7:0] LOCK_CNT [4]  = '{8'h05, 8'h10, 8'h40, 8'hFF};
   typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_RELOCK} pho_state_e;
   typedef struct packed {
      logic       dis;
      logic       win_lo;
      logic [1:0] cnt_code;
   } pho_ld_cfg_s;
endpackage
`default_nettype wire

// *** verilog/pho_sync.sv ***
/*
 * two flip-flop synchroniser, one per bit.
 * assumes inputs are asynchronous levels; reset value per bit.
 */
`timescale 1ns/1ps
`default_nettype none
module pho_sync #(
   parameter int         W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         core_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic meta_reg;
         always_ff @(posedge core_clk_i or posedge sys_rst_i)
         begin
            if (sys_rst_i)
            begin
               meta_reg  <= RST[i];
               sync_o[i] <= RST[i];
            end
            else
            begin
               meta_reg  <= async_i[i];
               sync_o[i] <= meta_reg;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire
